// ### inc/clc_pkg.sv
// Package: constants, types and timing counts of the character LCD controller core
package clc_pkg;
  localparam int FRAME_DIV        = 3072;
  localparam int RESET_CYCLES     = 3;
  localparam int CLEAR_CYCLES     = 165;
  localparam int STD_CYCLES       = 3;
  localparam int RAM_DEPTH        = 128;
  localparam int BUSY_CNT_W       = 8;
  localparam int FRAME_CNT_W      = 12;
  localparam logic [6:0] ADDR_ZERO    = 7'h00;
  localparam logic [6:0] ONE_LINE_END = 7'h4f;
  localparam logic [6:0] LINE1_END    = 7'h27;
  localparam logic [6:0] LINE2_START  = 7'h40;
  localparam logic [6:0] LINE2_END    = 7'h67;
  localparam logic [7:0] BLANK_CODE   = 8'h20;
  localparam logic [3:0] CHAR_RAM_COLUMN = 4'h0;
  localparam int DISPLAY_COLS     = 24;
  localparam int ICONS_BLINK      = 6;
  localparam int ICONS_STEADY     = 3;
  localparam int BIT_BUSY         = 7;
  localparam int BIT_DISPLAY_RAM_SEL    = 7;
  localparam int BIT_CHARACTER_RAM_SEL    = 6;
  localparam int BIT_FUNC_SET     = 5;
  localparam int BIT_SHIFT_CMD    = 4;
  localparam int BIT_DISP_CTRL    = 3;
  localparam int BIT_ENTRY        = 2;
  localparam int BIT_HOME         = 1;
  localparam int BIT_CLEAR        = 0;
  localparam logic [7:0] CMD_CLEAR = 8'h01;
  typedef enum logic [2:0] {ST_RESET, ST_CLEAR, ST_IDLE, ST_EXEC, ST_READ} clc_state_t;
endpackage

// ### src/clc_ram.sv
// Memory: display and character RAM with registered read data
`timescale 1ns/1ps
module clc_ram #(
  parameter int DEPTH = 128,
  parameter int AW    = 7
) (
  input  wire logic          sys_clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [7:0]    wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [7:0]    rdata
);
  logic [7:0] mem [DEPTH];
  initial begin
    if (DEPTH > (1 << AW)) begin
      $error("clc_ram: depth exceeds address width");
    end
  end
  // No reset on the array; display RAM contents are defined by the clear sweep
  always_ff @(posedge sys_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// ### src/clc_core.sv
// Core control logic of the character LCD controller
`timescale 1ns/1ps
// Summary of operation
// R1 - Frame tick is oscillator divided by 3072
// R2 - Host stops clock only during power down
// R3 - Reset takes 3 cycles, then clear
// R4 - Power down stops oscillator, grounds outputs
// R5 - Power down holds reset, exits via clear
// R6 - Host reinitialises after every power down
// R7 - Two 8-bit registers chosen by select
// R8 - Instruction register is never read back
// R9 - Read data is fetched before presentation
// R10 - Busy flag high refuses new instructions
// R11 - Status read drives busy on bit7
// R12 - Host waits for busy clear first
// R13 - Counter loaded by commands, steps by one
// R14 - Status read drives counter on bits 6-0
// R15 - Display RAM holds 80 codes
// R16 - Access stepping wraps per line mode
// R17 - Display shift wraps within each line
// R18 - Unshifted line one shows first 24
// R19 - First code column maps to character RAM
// R20 - Cursor at counter, suppressed on character RAM
// R21 - Host activity never disturbs internal timing
// R22 - Reset clear takes 165 cycles, busy set
// R23 - Line count selects drive and bias
// R24 - Icon entries: 6 blink, 3 steady, 0
// R25 - Instructions while busy are discarded
// R26 - Select 0 instruction/status, 1 data
// R27 - Transfers happen on strobe falling edge
// R28 - Strobe and select synchronised before decode
// R29 - Busy set on accept, cleared after count
module clc_core
  import clc_pkg::*;
#(
  parameter int CLEAR_LEN = CLEAR_CYCLES
) (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       power_down_input,
  input  wire logic       strobe,
  input  wire logic       register_select,
  input  wire logic       read_not_write,
  input  wire logic [7:0] db_in,
  output logic      [7:0] db_out,
  output logic            db_oe,
  output logic            busy_flag,
  output logic [6:0]      address_counter,
  output logic            frame_tick,
  output logic            osc_enable,
  output logic            bias_enable,
  output logic            drivers_grounded,
  output logic            two_line_mode,
  output logic            cursor_visible,
  output logic [6:0]      cursor_addr,
  output logic [6:0]      shift_offset,
  output logic [2:0]      icon_entries
);
  import clc_pkg::*;

  // The clear sweep must reach every display RAM place and still fit the busy counter
  initial begin
    if (CLEAR_LEN < RAM_DEPTH || CLEAR_LEN > (1 << BUSY_CNT_W) - 1) begin
      $error("clc_core: clear length out of range");
    end
  end

  typedef struct packed {
    clc_state_t             state;
    logic [BUSY_CNT_W-1:0]  cnt;
    logic [FRAME_CNT_W-1:0] frame_cnt;
    logic                   frame_tick;
    logic [2:0]             e_sync;
    logic [1:0]             rs_sync;
    logic [1:0]             rw_sync;
    logic [7:0]             instruction_register;
    logic [7:0]             data_register;
    logic [6:0]             address_counter;
    logic                   char_ram_sel;
    logic                   inc_mode;
    logic                   shift_en;
    logic                   two_line;
    logic                   ext_set;
    logic                   disp_on;
    logic                   cursor_on;
    logic                   icon_mode;
    logic                   icon_blink;
    logic [6:0]             shift;
    logic                   pending_step;
    logic [7:0]             db_out;
    logic                   db_oe;
  } clc_reg_t;

  clc_reg_t r;
  clc_reg_t next_r;
  logic     ram_we;
  logic [7:0] ram_waddr;
  logic [7:0] ram_wdata;
  logic [7:0] ram_rdata;
  logic     e_fall;

  // Address stepping with line-mode wrap
  function automatic logic [6:0] step_addr(input logic [6:0] a, input logic up, input logic two);
    logic [6:0] n;
    n = up ? 7'(a + 7'h01) : 7'(a - 7'h01);
    if (!two) begin
      if (up && a == ONE_LINE_END) n = ADDR_ZERO;                // [R16]
      if (!up && a == ADDR_ZERO) n = ONE_LINE_END;               // [R16]
    end else begin
      if (up && a == LINE1_END) n = LINE2_START;                 // [R16]
      if (up && a == LINE2_END) n = ADDR_ZERO;                   // [R16]
      if (!up && a == LINE2_START) n = LINE1_END;                // [R16]
      if (!up && a == ADDR_ZERO) n = LINE2_END;                  // [R16]
    end
    return n;
  endfunction

  // Shift offset wraps inside the line length
  function automatic logic [6:0] step_shift(input logic [6:0] s, input logic up, input logic two);
    logic [6:0] lim;
    logic [6:0] n;
    lim = two ? LINE1_END : ONE_LINE_END;
    if (up) n = (s >= lim) ? ADDR_ZERO : 7'(s + 7'h01);          // [R17]
    else    n = (s == ADDR_ZERO) ? lim : 7'(s - 7'h01);          // [R17]
    return n;
  endfunction

  // Second stage feeds the edge detector and the read drive; first stage stays private
  assign e_fall = r.e_sync[2] & ~r.e_sync[1];                    // [R27] [R28]

  // Display RAM in the lower half, character RAM in the upper half, so the two never alias
  // Read address is the next counter value, so read data always follows the live counter
  clc_ram #(
    .DEPTH(2 * RAM_DEPTH),
    .AW   (8)
  ) u_ram (                                                      // [R15] [R19]
    .sys_clk(sys_clk),
    .we     (ram_we),
    .waddr  (ram_waddr),
    .wdata  (ram_wdata),
    .raddr  ({next_r.char_ram_sel, next_r.address_counter}),     // [R9]
    .rdata  (ram_rdata)
  );

  // Next-state logic for the whole core
  always_comb begin
    next_r = r;
    ram_we = 1'b0;
    ram_waddr = {r.char_ram_sel, r.address_counter};
    ram_wdata = r.data_register;
    next_r.e_sync  = {r.e_sync[1:0], strobe};                    // [R28]
    next_r.rs_sync = {r.rs_sync[0], register_select};            // [R28]
    next_r.rw_sync = {r.rw_sync[0], read_not_write};             // [R28]
    // Free-running divider; host traffic never touches it
    next_r.frame_tick = 1'b0;
    if (r.frame_cnt == FRAME_CNT_W'(FRAME_DIV - 1)) begin        // [R1] [R21]
      next_r.frame_cnt  = '0;
      next_r.frame_tick = 1'b1;
    end else begin
      next_r.frame_cnt = FRAME_CNT_W'(r.frame_cnt + 1'b1);
    end
    // Bus released after the falling edge of the strobe
    if (e_fall) next_r.db_oe = 1'b0;
    if (r.e_sync[1] && r.rw_sync[1]) begin
      next_r.db_oe = 1'b1;
      if (!r.rs_sync[1]) begin
        next_r.db_out = {r.state != ST_IDLE, r.address_counter}; // [R11] [R14] [R26]
      end else begin
        next_r.db_out = r.data_register;                         // [R8] [R9] [R26]
      end
    end
    unique case (r.state)
      ST_RESET: begin
        if (r.cnt == BUSY_CNT_W'(RESET_CYCLES - 1)) begin        // [R3]
          next_r.state = ST_CLEAR;
          next_r.cnt   = '0;
        end else begin
          next_r.cnt = BUSY_CNT_W'(r.cnt + 1'b1);
        end
      end
      ST_CLEAR: begin
        // Sweep writes blanks while busy stays high
        ram_we    = r.cnt < BUSY_CNT_W'(RAM_DEPTH);
        ram_waddr = {1'b0, r.cnt[6:0]};
        ram_wdata = BLANK_CODE;
        if (r.cnt == BUSY_CNT_W'(CLEAR_LEN - 1)) begin           // [R22] [R29]
          // Read cycle follows so the data register holds the blank at address zero
          next_r.state = ST_READ;
          next_r.address_counter = ADDR_ZERO;
          next_r.char_ram_sel = 1'b0;
          next_r.shift = ADDR_ZERO;
          next_r.inc_mode = 1'b1;
        end else begin
          next_r.cnt = BUSY_CNT_W'(r.cnt + 1'b1);
        end
      end
      ST_IDLE: begin
        // Writes taken at the strobe falling edge only when idle
        if (e_fall && !r.rw_sync[1]) begin                       // [R10] [R25] [R27]
          next_r.cnt = '0;
          next_r.state = ST_EXEC;                                // [R29]
          if (r.rs_sync[1]) begin
            next_r.data_register = db_in;                        // [R7]
            ram_we = 1'b1;
            ram_wdata = db_in;                                   // [R7]
            next_r.pending_step = 1'b1;                          // [R13]
            if (r.shift_en && !r.char_ram_sel) begin
              next_r.shift = step_shift(r.shift, !r.inc_mode, r.two_line); // [R17]
            end
          end else begin
            next_r.instruction_register = db_in;                 // [R7] [R8]
            if (db_in == CMD_CLEAR && !r.ext_set) begin
              next_r.state = ST_CLEAR;
            end else if (db_in[BIT_DISPLAY_RAM_SEL]) begin
              next_r.address_counter = db_in[6:0];               // [R13]
              next_r.char_ram_sel = 1'b0;
            end else if (db_in[BIT_CHARACTER_RAM_SEL]) begin
              next_r.address_counter = {1'b0, db_in[5:0]};       // [R13]
              next_r.char_ram_sel = 1'b1;
            end else if (db_in[BIT_FUNC_SET]) begin
              next_r.two_line = db_in[2];                        // [R23]
              next_r.ext_set  = db_in[0];
            end else if (!r.ext_set && db_in[BIT_SHIFT_CMD]) begin
              if (db_in[3]) next_r.shift = step_shift(r.shift, db_in[2], r.two_line); // [R17]
              else next_r.address_counter = step_addr(r.address_counter, db_in[2], r.two_line);
            end else if (db_in[BIT_DISP_CTRL]) begin
              if (r.ext_set) begin
                next_r.icon_mode  = db_in[2];
                next_r.icon_blink = db_in[1];
              end else begin
                next_r.disp_on   = db_in[2];
                next_r.cursor_on = db_in[1] | db_in[0];
              end
            end else if (!r.ext_set && db_in[BIT_ENTRY]) begin
              next_r.inc_mode = db_in[1];
              next_r.shift_en = db_in[0];
            end else if (!r.ext_set && db_in[BIT_HOME]) begin
              next_r.address_counter = ADDR_ZERO;
              next_r.char_ram_sel = 1'b0;
              next_r.shift = ADDR_ZERO;
            end
          end
        end else if (e_fall && r.rs_sync[1]) begin
          // Data read consumed: refetch and step
          next_r.state = ST_EXEC;
          next_r.cnt = '0;
          next_r.pending_step = 1'b1;                            // [R13]
        end
      end
      ST_EXEC: begin
        if (r.cnt == BUSY_CNT_W'(STD_CYCLES - 1)) begin          // [R29]
          next_r.state = ST_READ;
          if (r.pending_step) begin
            next_r.address_counter = r.char_ram_sel ? 7'(r.address_counter + (r.inc_mode ? 7'h01 : 7'h7f)) & 7'h3f
                                   : step_addr(r.address_counter, r.inc_mode, r.two_line); // [R16]
            next_r.pending_step = 1'b0;
          end
        end else begin
          next_r.cnt = BUSY_CNT_W'(r.cnt + 1'b1);
        end
      end
      ST_READ: begin
        // One cycle lets RAM read data follow the new address
        next_r.data_register = ram_rdata;                        // [R9]
        next_r.state = ST_IDLE;
      end
    endcase
  end

  // Power down holds everything in reset; release restarts with the clear
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      r <= '{state: ST_RESET, inc_mode: 1'b1, default: '0};      // [R3]
    end else if (power_down_input) begin
      r <= '{state: ST_RESET, inc_mode: 1'b1, default: '0};      // [R5]
    end else begin
      r <= next_r;
    end
  end

  assign busy_flag        = r.state != ST_IDLE;                  // [R10]
  assign address_counter  = r.address_counter;
  assign db_out           = r.db_out;
  assign db_oe            = r.db_oe;
  assign frame_tick       = r.frame_tick;
  assign osc_enable       = ~power_down_input;                   // [R4]
  assign bias_enable      = ~power_down_input & r.disp_on;       // [R4]
  assign drivers_grounded = power_down_input | ~r.disp_on;       // [R4]
  assign two_line_mode    = r.two_line;                          // [R23]
  assign cursor_visible   = r.cursor_on & ~r.char_ram_sel;       // [R20]
  assign cursor_addr      = r.address_counter;                   // [R20]
  assign shift_offset     = r.shift;                             // [R18]
  assign icon_entries     = r.icon_mode ? (r.icon_blink ? 3'(ICONS_BLINK) : 3'(ICONS_STEADY)) : 3'h0; // [R24]

  // Status read, refusal and timing checks
  status_bit_a: assert property (@(posedge sys_clk) disable iff (rst)  // [R11]
    (r.e_sync[1] && r.rw_sync[1] && !r.rs_sync[1]) |=> (db_out[BIT_BUSY] == $past(busy_flag)))
    else $error("status read busy bit wrong");
  status_addr_a: assert property (@(posedge sys_clk) disable iff (rst)  // [R14]
    (r.e_sync[1] && r.rw_sync[1] && !r.rs_sync[1]) |=> (db_out[6:0] == $past(address_counter)))
    else $error("status read address wrong");
  busy_refuse_a: assert property (@(posedge sys_clk) disable iff (rst || power_down_input)  // [R25]
    (busy_flag && r.state != ST_READ) |=> $stable(r.instruction_register))
    else $error("instruction taken while busy");
  exec_len_a: assert property (@(posedge sys_clk) disable iff (rst || power_down_input)  // [R29]
    ($rose(r.state == ST_EXEC)) |-> (r.state == ST_EXEC) [*3] ##1 (r.state == ST_READ))
    else $error("instruction time not three cycles");
  reset_len_a: assert property (@(posedge sys_clk) disable iff (rst || power_down_input)  // [R3]
    ($fell(r.state == ST_RESET)) |-> (r.state == ST_CLEAR && $past(r.cnt) == 8'h02))
    else $error("reset not three cycles");
  clear_done_a: assert property (@(posedge sys_clk) disable iff (rst || power_down_input)  // [R22]
    ($fell(r.state == ST_CLEAR)) |-> (address_counter == ADDR_ZERO && $past(r.cnt) == 8'(CLEAR_LEN - 1)))
    else $error("clear length or home wrong");
  frame_div_a: assert property (@(posedge sys_clk) disable iff (rst || power_down_input)  // [R1]
    frame_tick |=> !frame_tick [*8])
    else $error("frame tick too frequent");
  cursor_cg_a: assert property (@(posedge sys_clk) disable iff (rst)  // [R20]
    r.char_ram_sel |-> !cursor_visible)
    else $error("cursor shown on character RAM");
  pd_ground_a: assert property (@(posedge sys_clk)  // [R4]
    power_down_input |-> (drivers_grounded && !osc_enable && !bias_enable))
    else $error("outputs active in power down");
  wrap_two_a: assert property (@(posedge sys_clk) disable iff (rst || power_down_input)  // [R16]
    (r.state == ST_EXEC && r.cnt == 8'h02 && r.pending_step && !r.char_ram_sel && r.two_line
     && r.inc_mode && r.address_counter == LINE1_END) |=> (address_counter == LINE2_START))
    else $error("two line wrap wrong");
  // Write path, refetch, shift range and power down checks
  ram_write_a: assert property (@(posedge sys_clk) disable iff (rst || power_down_input)  // [R7]
    (r.state == ST_IDLE && e_fall && !r.rw_sync[1] && r.rs_sync[1]) |-> (ram_we && ram_wdata == db_in))
    else $error("data write not stored");
  busy_accept_a: assert property (@(posedge sys_clk) disable iff (rst || power_down_input)  // [R29]
    (r.state == ST_IDLE && e_fall && !r.rw_sync[1]) |=> busy_flag)
    else $error("busy not set on accept");
  read_fetch_a: assert property (@(posedge sys_clk) disable iff (rst || power_down_input)  // [R9]
    (r.state == ST_READ) |=> (r.data_register == $past(ram_rdata)))
    else $error("data register not refetched");
  clear_busy_a: assert property (@(posedge sys_clk) disable iff (rst)  // [R22]
    (r.state == ST_CLEAR) |-> busy_flag)
    else $error("busy low during clear");
  shift_range_a: assert property (@(posedge sys_clk) disable iff (rst)  // [R17]
    shift_offset <= ONE_LINE_END)
    else $error("shift offset out of range");
  pd_reset_a: assert property (@(posedge sys_clk) disable iff (rst)  // [R5]
    power_down_input |=> (r.state == ST_RESET))
    else $error("power down does not hold reset");
endmodule

// ### tb/clc_host.sv
// Host microcontroller model on the parallel bus of the controller core
`timescale 1ns/1ps
module clc_host (
  input  wire logic       sys_clk,
  output logic            strobe,
  output logic            register_select,
  output logic            read_not_write,
  output logic [7:0]      bus_level,
  input  wire logic [7:0] db_out,
  input  wire logic       db_oe
);
  logic       host_oe;
  logic [7:0] host_data;

  // Wire level: host, else device, else the pull-ups on every data line
  assign bus_level = host_oe ? host_data : (db_oe ? db_out : 8'hff);

  // Idle bus at time zero
  initial begin
    strobe = 1'b0;
    register_select = 1'b1;
    read_not_write = 1'b1;
    host_oe = 1'b0;
    host_data = 8'h00;
  end

  // One access: strobe high six clocks, transfer at its fall, data held well past the slow fall detect
  task automatic access(input logic rs, input logic rnw, input logic [7:0] wdata, output logic [7:0] rdata);
    @(posedge sys_clk);
    strobe          <= 1'b1;
    register_select <= rs;
    read_not_write  <= rnw;
    host_data       <= wdata;
    host_oe         <= ~rnw;
    repeat (6) @(posedge sys_clk);
    rdata = bus_level;
    strobe          <= 1'b0;
    repeat (6) @(posedge sys_clk);
    host_oe         <= 1'b0;
    read_not_write  <= 1'b1;
  endtask
endmodule

// ### tb/testbench.sv
// Self-checking testbench for the character LCD controller core
`timescale 1ns/1ps
module testbench;
  import clc_pkg::*;
  localparam int CLEAR_SHORT = 140;  // Shortened clear, still covers all 128 RAM places
  localparam int LIMIT       = 20000;
  logic       sys_clk;
  logic       rst;
  logic       power_down_input;
  logic       strobe;
  logic       register_select;
  logic       read_not_write;
  logic [7:0] bus_level;
  logic [7:0] db_out;
  logic       db_oe;
  logic       busy_flag;
  logic [6:0] address_counter;
  logic       frame_tick;
  logic       osc_enable;
  logic       bias_enable;
  logic       drivers_grounded;
  logic       two_line_mode;
  logic       cursor_visible;
  logic [6:0] cursor_addr;
  logic [6:0] shift_offset;
  logic [2:0] icon_entries;
  logic [7:0] v;
  int         failures;
  int         checks_done;
  int         cycles;

  clc_core #(.CLEAR_LEN(CLEAR_SHORT)) u_clc_core (
    .sys_clk(sys_clk), .rst(rst), .power_down_input(power_down_input), .strobe(strobe),
    .register_select(register_select), .read_not_write(read_not_write), .db_in(bus_level),
    .db_out(db_out), .db_oe(db_oe), .busy_flag(busy_flag), .address_counter(address_counter),
    .frame_tick(frame_tick), .osc_enable(osc_enable), .bias_enable(bias_enable),
    .drivers_grounded(drivers_grounded), .two_line_mode(two_line_mode), .cursor_visible(cursor_visible),
    .cursor_addr(cursor_addr), .shift_offset(shift_offset), .icon_entries(icon_entries)
  );
  clc_host u_clc_host (
    .sys_clk(sys_clk), .strobe(strobe), .register_select(register_select),
    .read_not_write(read_not_write), .bus_level(bus_level), .db_out(db_out), .db_oe(db_oe)
  );

  // 125 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic cmp1(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmp_count(input string what, input int exp, input int got);
    checks_done++;
    if (got != exp) begin
      failures++;
      $display("unexpected %s: expected %0d seen %0d", what, exp, got);
    end
  endtask

  // Bounded wait so a stuck busy flag cannot hang the run
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy_flag !== 1'b0 && n < 400) begin
      @(posedge sys_clk);
      n++;
    end
    cmp1("idle reached", 1'b1, n < 400);
  endtask
  task automatic wr(input logic rs, input logic [7:0] d);
    logic [7:0] junk;
    u_clc_host.access(rs, 1'b0, d, junk);
    wait_idle();
  endtask
  task automatic rd(input logic rs, output logic [7:0] d);
    u_clc_host.access(rs, 1'b1, 8'h00, d);
    wait_idle();
  endtask

  // Busy spans the reset steps and the automatic clear
  task automatic t_reset();
    int n;
    n = 0;
    cmp1("busy in reset", 1'b1, busy_flag);
    @(posedge sys_clk);
    rst <= 1'b0;
    while (busy_flag === 1'b1 && n < 400) begin
      @(posedge sys_clk);
      n++;
    end
    cmp1("reset busy span", 1'b1, n >= RESET_CYCLES + CLEAR_SHORT && n <= RESET_CYCLES + CLEAR_SHORT + 3);
    cmp1("grounded after reset", 1'b1, drivers_grounded);
    rd(1'b0, v);
    cmp8("status after reset", 8'h00, v);
  endtask

  // Two-line stepping across both line ends, read-back through the data register
  task automatic t_ram();
    wr(1'b0, 8'h34);
    cmp1("two line mode", 1'b1, two_line_mode);
    wr(1'b0, 8'ha7);
    rd(1'b0, v);
    cmp8("status after load", 8'h27, v);
    wr(1'b1, 8'h41);
    rd(1'b0, v);
    cmp8("step past line one", 8'h40, v);
    wr(1'b1, 8'h55);
    wr(1'b0, 8'he7);
    wr(1'b1, 8'h66);
    rd(1'b0, v);
    cmp8("step past line two", 8'h00, v);
    wr(1'b0, 8'ha7);
    rd(1'b1, v);
    cmp8("read at 27", 8'h41, v);
    rd(1'b0, v);
    cmp8("step after read", 8'h40, v);
    rd(1'b1, v);
    cmp8("read at 40", 8'h55, v);
    wr(1'b0, 8'h85);
    rd(1'b1, v);
    cmp8("cleared location", BLANK_CODE, v);
    wr(1'b0, 8'h30);
    cmp1("one line mode", 1'b0, two_line_mode);
    wr(1'b0, 8'hcf);
    wr(1'b1, 8'h4e);
    rd(1'b0, v);
    cmp8("single line wrap", 8'h00, v);
    wr(1'b0, 8'hcf);
    rd(1'b1, v);
    cmp8("location 4f kept", 8'h4e, v);
  endtask

  // An instruction sent during the long clear is dropped
  task automatic t_busy();
    logic [7:0] junk;
    u_clc_host.access(1'b0, 1'b0, CMD_CLEAR, junk);
    u_clc_host.access(1'b0, 1'b1, 8'h00, v);
    cmp1("busy bit during clear", 1'b1, v[7]);
    u_clc_host.access(1'b0, 1'b0, 8'h90, junk);
    wait_idle();
    rd(1'b0, v);
    cmp8("status after drop", 8'h00, v);
  endtask

  // Cursor follows a display address and vanishes on a character RAM address
  task automatic t_cursor();
    wr(1'b0, 8'h0e);
    cmp1("display on", 1'b0, drivers_grounded);
    wr(1'b0, 8'h83);
    cmp1("cursor shown", 1'b1, cursor_visible);
    cmp8("cursor place", 8'h03, {1'b0, cursor_addr});
    wr(1'b0, 8'h42);
    cmp1("cursor hidden", 1'b0, cursor_visible);
    rd(1'b0, v);
    cmp8("char ram address", 8'h02, v);
    wr(1'b0, 8'h18);
    cmp8("shift wraps left", 8'h4f, {1'b0, shift_offset});
    wr(1'b0, 8'h1c);
    cmp8("shift wraps right", 8'h00, {1'b0, shift_offset});
  endtask

  // Icon rows draw 6, 3 or no character RAM entries
  task automatic t_icons();
    wr(1'b0, 8'h35);
    wr(1'b0, 8'h0e);
    cmp8("icons blinking", 8'h06, {5'h00, icon_entries});
    wr(1'b0, 8'h0c);
    cmp8("icons steady", 8'h03, {5'h00, icon_entries});
    wr(1'b0, 8'h08);
    cmp8("icons off", 8'h00, {5'h00, icon_entries});
    wr(1'b0, 8'h34);
    cmp1("basic set again", 1'b1, two_line_mode);
  endtask

  // Frame period measured between two ticks
  task automatic t_frame();
    int n;
    n = 0;
    while (frame_tick !== 1'b1 && n < 4000) begin
      @(posedge sys_clk);
      n++;
    end
    n = 0;
    @(posedge sys_clk);
    while (frame_tick !== 1'b1 && n < 4000) begin
      @(posedge sys_clk);
      n++;
    end
    cmp_count("frame period", FRAME_DIV, n + 1);
  endtask

  // Power down grounds the drivers, then a fresh clear follows
  task automatic t_power();
    power_down_input <= 1'b1;
    repeat (3) @(posedge sys_clk);
    cmp1("grounded in power down", 1'b1, drivers_grounded);
    cmp1("oscillator off", 1'b0, osc_enable);
    cmp1("bias off", 1'b0, bias_enable);
    cmp1("busy in power down", 1'b1, busy_flag);
    power_down_input <= 1'b0;
    repeat (2) @(posedge sys_clk);
    cmp1("busy after power down", 1'b1, busy_flag);
    wait_idle();
    rd(1'b0, v);
    cmp8("status after power down", 8'h00, v);
    cmp1("lines reset by power down", 1'b0, two_line_mode);
    rd(1'b1, v);
    cmp8("blank after power down", BLANK_CODE, v);
    wr(1'b0, 8'h34);
    cmp1("lines after reinit", 1'b1, two_line_mode);
  endtask

  task automatic close_out();
    $display("checks_done %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      failures++;
      close_out();
    end
  end

  initial begin
    rst = 1'b1;
    power_down_input = 1'b0;
    failures = 0;
    checks_done = 0;
    cycles = 0;
    repeat (6) @(posedge sys_clk);
    t_reset();
    t_ram();
    t_busy();
    t_cursor();
    t_icons();
    t_frame();
    t_power();
    close_out();
  end
endmodule
